// ### hw/pdt_timer.v
// timer section: 24-bit down counter, reload bytes, flags, vector, pins
// assumes bus strobes and acknowledge input are synchronous to clk
`include "pdt_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module pdt_timer
(
    input  wire       clk,
    input  wire       reset_n,
    input  wire       bus_cs_n,
    input  wire       bus_rd_wr,
    input  wire [4:0] bus_addr,
    input  wire [7:0] bus_wdata,
    output wire [7:0] bus_rdata,
    output wire       bus_rdata_oe,
    output wire       bus_transfer_ack_n,
    input  wire       timer_int_ack_pin_n,
    input  wire       ext_timer_input,
    output wire       timer_output_pin,
    output wire       timer_output_oe,
    output wire       timer_int_ack_sel,
    output wire       ext_input_sel,
    output wire       zero_reached_flag
);
    reg  [7:0]  timer_config_reg_ff;
    reg  [7:0]  timer_vector_reg_ff;
    reg  [7:0]  reload_high_ff;
    reg  [7:0]  reload_middle_ff;
    reg  [7:0]  reload_low_ff;
    reg  [23:0] count_ff;
    reg  [23:0] nxt_count;
    reg         zero_flag_ff;
    reg         nxt_zero_flag;
    reg         first_step_ff;
    reg         square_ff;
    reg         busy_ff;
    reg         ack_ff;
    reg         oe_ff;
    reg  [7:0]  rdata_ff;
    reg  [7:0]  rd_mux;
    reg  [7:0]  nxt_config;
    reg  [7:0]  nxt_vector;
    reg  [7:0]  nxt_reload_high;
    reg  [7:0]  nxt_reload_middle;
    reg  [7:0]  nxt_reload_low;
    reg         nxt_busy;
    reg         nxt_ack;
    reg         nxt_oe;
    reg  [7:0]  nxt_rdata;

    wire        enable;
    wire [1:0]  clk_ctrl;
    wire [1:0]  pin_ctrl;
    wire        zd_roll;
    wire        irq_enable;
    wire        ext_level;
    wire        ext_rise;
    wire        run;
    wire        presc_tick;
    wire        presc_roll;
    wire        step;
    wire        zero_event;
    wire        irq_active;
    wire        bus_take;
    wire        iack_take;
    wire        wr_take;
    wire        flag_clear;
    wire [23:0] reload_value;

    assign enable     = timer_config_reg_ff[`PDT_CFG_ENABLE];
    assign clk_ctrl   = timer_config_reg_ff[`PDT_CFG_CLK_HI:`PDT_CFG_CLK_LO];
    assign pin_ctrl   = timer_config_reg_ff[`PDT_CFG_PIN_HI:`PDT_CFG_PIN_LO+1];
    assign zd_roll    = timer_config_reg_ff[`PDT_CFG_ZD_ROLL];
    assign irq_enable = timer_config_reg_ff[`PDT_CFG_PIN_LO];
    assign reload_value = {reload_high_ff, reload_middle_ff, reload_low_ff};

    pdt_ext_sync u_sync
    (
        .clk     (clk),
        .reset_n (reset_n),
        .ext_in  (ext_timer_input),
        .level   (ext_level),
        .rise    (ext_rise)
    );

    // gated mode halts whenever the input is low
    assign run = enable & ((clk_ctrl != `PDT_CLK_SYS_GATED) | ext_level);

    // system clock feeds the prescaler every cycle; 32 cycles per step keeps rate legal
    assign presc_tick = (clk_ctrl == `PDT_CLK_EXT_PRESC) ? ext_rise : 1'b1;

    pdt_prescaler u_presc
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (run & (clk_ctrl != `PDT_CLK_EXT_DIRECT)),
        .tick     (presc_tick),
        .rollover (presc_roll)
    );

    // direct mode relies on external edges no faster than clk/8
    assign step = run & ((clk_ctrl == `PDT_CLK_EXT_DIRECT) ? ext_rise : presc_roll);

    assign zero_event = step & ~first_step_ff & (count_ff == `PDT_COUNT_ONE);

    // counter: no reset on purpose, contents survive the reset pin
    always @*
    begin
        nxt_count = count_ff;
        if (step)
        begin
            if (first_step_ff)
                nxt_count = reload_value;
            else if ((count_ff == `PDT_COUNT_ZERO) && !zd_roll)
                nxt_count = reload_value;
            else
                nxt_count = count_ff - `PDT_COUNT_ONE;
        end
    end

    always @(posedge clk)
    begin
        count_ff <= nxt_count;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            first_step_ff <= 1'b1;
        else if (!run)
            first_step_ff <= 1'b1;
        else if (step)
            first_step_ff <= 1'b0;
    end

    // zero flag: set wins over a coinciding clear, halt wins over both
    assign flag_clear = wr_take && (bus_addr == `PDT_OFS_FLAGS)
                        && bus_wdata[`PDT_FLAG_ZERO];

    always @*
    begin
        nxt_zero_flag = zero_flag_ff;
        if (!run)
            nxt_zero_flag = 1'b0;
        else if (zero_event)
            nxt_zero_flag = 1'b1;
        else if (flag_clear)
            nxt_zero_flag = 1'b0;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            zero_flag_ff <= 1'b0;
        else
            zero_flag_ff <= nxt_zero_flag;
    end

    assign zero_reached_flag = zero_flag_ff;

    // square wave level
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            square_ff <= 1'b1;
        else if (!run)
            square_ff <= 1'b1;
        else if (zero_event)
            square_ff <= ~square_ff;
    end

    // timer pin: port function leaves it undriven, request is open drain low
    assign irq_active = pin_ctrl[1] & irq_enable & zero_flag_ff;
    assign timer_output_pin = (pin_ctrl == `PDT_PIN_SQUARE) ? square_ff : 1'b0;
    assign timer_output_oe  = (pin_ctrl == `PDT_PIN_SQUARE) | irq_active;
    assign timer_int_ack_sel = (pin_ctrl == `PDT_PIN_IRQ_VEC);
    assign ext_input_sel = (clk_ctrl != `PDT_CLK_SYS);

    // bus cycle taken once per strobe; ack held until strobe released
    assign bus_take  = ~bus_cs_n & ~busy_ff;
    assign iack_take = bus_cs_n & ~timer_int_ack_pin_n & ~busy_ff
                       & timer_int_ack_sel & irq_active;
    assign wr_take   = bus_take & ~bus_rd_wr;

    always @*
    begin
        case (bus_addr)
            `PDT_OFS_CONFIG:
                rd_mux = timer_config_reg_ff & ~(8'h01 << `PDT_CFG_UNUSED);
            `PDT_OFS_VECTOR:     rd_mux = timer_vector_reg_ff;
            `PDT_OFS_NULL_RELOAD: rd_mux = `PDT_ZERO_BYTE;
            `PDT_OFS_RELOAD_HI:  rd_mux = reload_high_ff;
            `PDT_OFS_RELOAD_MID: rd_mux = reload_middle_ff;
            `PDT_OFS_RELOAD_LO:  rd_mux = reload_low_ff;
            `PDT_OFS_NULL_COUNT: rd_mux = `PDT_ZERO_BYTE;
            `PDT_OFS_COUNT_HI:   rd_mux = count_ff[23:16];
            `PDT_OFS_COUNT_MID:  rd_mux = count_ff[15:8];
            `PDT_OFS_COUNT_LO:   rd_mux = count_ff[7:0];
            `PDT_OFS_FLAGS:      rd_mux = {7'h00, zero_flag_ff};
            default:             rd_mux = `PDT_ZERO_BYTE;
        endcase
    end

    // bus answer next state: register cycle wins over a coinciding acknowledge
    always @*
    begin
        nxt_busy  = busy_ff;
        nxt_ack   = ack_ff;
        nxt_oe    = oe_ff;
        nxt_rdata = rdata_ff;
        if (bus_take)
        begin
            nxt_busy  = 1'b1;
            nxt_ack   = 1'b1;
            nxt_oe    = bus_rd_wr;
            nxt_rdata = bus_rd_wr ? rd_mux : `PDT_ZERO_BYTE;
        end
        else if (iack_take)
        begin
            nxt_busy  = 1'b1;
            nxt_ack   = 1'b1;
            nxt_oe    = 1'b1;
            nxt_rdata = timer_vector_reg_ff;
        end
        else if (bus_cs_n && timer_int_ack_pin_n)
        begin
            nxt_busy  = 1'b0;
            nxt_ack   = 1'b0;
            nxt_oe    = 1'b0;
            nxt_rdata = `PDT_ZERO_BYTE;
        end
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_ff  <= 1'b0;
            ack_ff   <= 1'b0;
            oe_ff    <= 1'b0;
            rdata_ff <= `PDT_ZERO_BYTE;
        end
        else
        begin
            busy_ff  <= nxt_busy;
            ack_ff   <= nxt_ack;
            oe_ff    <= nxt_oe;
            rdata_ff <= nxt_rdata;
        end
    end

    assign bus_transfer_ack_n = ~ack_ff;
    assign bus_rdata    = rdata_ff;
    assign bus_rdata_oe = oe_ff;

    // control and vector registers
    always @*
    begin
        nxt_config = timer_config_reg_ff;
        nxt_vector = timer_vector_reg_ff;
        if (wr_take && (bus_addr == `PDT_OFS_CONFIG))
            nxt_config = bus_wdata;
        if (wr_take && (bus_addr == `PDT_OFS_VECTOR))
            nxt_vector = bus_wdata;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            timer_config_reg_ff <= `PDT_CONFIG_RST;
            timer_vector_reg_ff <= `PDT_VECTOR_RST;
        end
        else
        begin
            timer_config_reg_ff <= nxt_config;
            timer_vector_reg_ff <= nxt_vector;
        end
    end

    // reload bytes: no reset and no interlock against a coinciding load
    always @*
    begin
        nxt_reload_high   = reload_high_ff;
        nxt_reload_middle = reload_middle_ff;
        nxt_reload_low    = reload_low_ff;
        if (wr_take && (bus_addr == `PDT_OFS_RELOAD_HI))
            nxt_reload_high = bus_wdata;
        if (wr_take && (bus_addr == `PDT_OFS_RELOAD_MID))
            nxt_reload_middle = bus_wdata;
        if (wr_take && (bus_addr == `PDT_OFS_RELOAD_LO))
            nxt_reload_low = bus_wdata;
    end

    // no reset branch: contents survive the reset pin
    always @(posedge clk)
    begin
        reload_high_ff   <= nxt_reload_high;
        reload_middle_ff <= nxt_reload_middle;
        reload_low_ff    <= nxt_reload_low;
    end
endmodule
`default_nettype wire

// ### hw/pdt_defs.vh
// constants of the prescaled down counter timer: offsets, fields, reset values
// assumes inclusion by bare name from the timer and prescaler design files of the timer
// Summary of operation
// - 8-bit vector register, read/write anytime, same value on read and acknowledge.
// - reset loads the vector register with 0F hex.
// - three addressable reload bytes high, middle, low form the 24-bit reload value.
// - byte below high reload and below high count reads zero, ignores writes.
// - reload bytes readable and writable anytime, no interlock against coinciding loads.
// - reset leaves reload bytes and 24-bit counter unchanged.
// - count windows read live counter unlatched; writes acknowledged, data dropped.
// - zero flag bit 0 set by the step from one to zero only.
// - status read has no side effect; writing bit 0 as one clears flag.
// - halt keeps counter, forces prescaler to 1F and zero flag to zero.
// - reset clears all control bits: timer halted, timer pins back to inputs.
// - run clocks counter from chosen source; prescaler decrements only when used.
// - counter stepped by divide-by-32 prescaler rollover or directly by external input.
// - with prescaler, first rollover after run loads counter; later ones step it.
// - without prescaler, first external edge after run loads; later edges step it.
// - zero flag is pollable and is the timer interrupt source.
// - zero-detect control 0 reloads on next step after zero; 1 rolls over.
// - interrupt enabled: request pin driven low while zero flag is one.
// - square wave: output toggles at each zero detect, high while halted.
// - gated mode: run only while enable is one and external input is high.
`ifndef PDT_DEFS_VH
`define PDT_DEFS_VH

// register offsets on the 5-bit register select
`define PDT_ADDR_W          5
`define PDT_OFS_CONFIG      5'h10
`define PDT_OFS_VECTOR      5'h11
`define PDT_OFS_NULL_RELOAD 5'h12
`define PDT_OFS_RELOAD_HI   5'h13
`define PDT_OFS_RELOAD_MID  5'h14
`define PDT_OFS_RELOAD_LO   5'h15
`define PDT_OFS_NULL_COUNT  5'h16
`define PDT_OFS_COUNT_HI    5'h17
`define PDT_OFS_COUNT_MID   5'h18
`define PDT_OFS_COUNT_LO    5'h19
`define PDT_OFS_FLAGS       5'h1a

// reset values
`define PDT_VECTOR_RST      8'h0f
`define PDT_CONFIG_RST      8'h00
`define PDT_PRESC_LOAD      5'h1f
`define PDT_PRESC_ZERO      5'h00
`define PDT_ZERO_BYTE       8'h00

// timer config field positions
`define PDT_CFG_ENABLE      0
`define PDT_CFG_CLK_LO      1
`define PDT_CFG_CLK_HI      2
`define PDT_CFG_UNUSED      3
`define PDT_CFG_ZD_ROLL     4
`define PDT_CFG_PIN_LO      5
`define PDT_CFG_PIN_HI      7
`define PDT_FLAG_ZERO       0

// clock control encodings
`define PDT_CLK_SYS         2'b00
`define PDT_CLK_SYS_GATED   2'b01
`define PDT_CLK_EXT_PRESC   2'b10
`define PDT_CLK_EXT_DIRECT  2'b11

// pin control encodings (bits 7..6)
`define PDT_PIN_PORT        2'b00
`define PDT_PIN_SQUARE      2'b01
`define PDT_PIN_IRQ_VEC     2'b10
`define PDT_PIN_IRQ_AUTO    2'b11

// counter constants
`define PDT_COUNT_ONE       24'h00_0001
`define PDT_COUNT_ZERO      24'h00_0000

`endif

// ### hw/pdt_ext_sync.v
// two-flop synchroniser and rising edge detect for the external timer input
// assumes ext_in may change at any time relative to clk
`timescale 1ns/1ps
`default_nettype none
module pdt_ext_sync
(
    input  wire clk,
    input  wire reset_n,
    input  wire ext_in,
    output wire level,
    output wire rise
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;

    // first flop feeds only the second one
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= ext_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
endmodule
`default_nettype wire

// ### hw/pdt_prescaler.v
// 5-bit divide-by-32 prescaler, forced to all ones while halted
// assumes tick is a one-cycle pulse from the selected prescaler source
`include "pdt_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module pdt_prescaler
(
    input  wire clk,
    input  wire reset_n,
    input  wire run,
    input  wire tick,
    output wire rollover
);
    reg [4:0] presc_ff;
    reg [4:0] nxt_presc;

    always @*
    begin
        nxt_presc = presc_ff;
        if (!run)
            nxt_presc = `PDT_PRESC_LOAD;
        else if (tick)
            nxt_presc = presc_ff - 5'h01;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            presc_ff <= `PDT_PRESC_LOAD;
        else
            presc_ff <= nxt_presc;
    end

    // 00 to 1F wrap is the counter step
    assign rollover = run & tick & (presc_ff == `PDT_PRESC_ZERO);
endmodule
`default_nettype wire

// ### bench/pdt_timer_props.sv
// checker: bus answer, acknowledge and request pin relations of the timer
// assumes a bind onto pdt_timer from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_props
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       bus_cs_n,
    input wire logic       bus_rd_wr,
    input wire logic [4:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata,
    input wire logic       bus_rdata_oe,
    input wire logic       bus_transfer_ack_n,
    input wire logic       timer_int_ack_pin_n,
    input wire logic       ext_timer_input,
    input wire logic       timer_output_pin,
    input wire logic       timer_output_oe,
    input wire logic       timer_int_ack_sel,
    input wire logic       ext_input_sel,
    input wire logic       zero_reached_flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_take_then_ack: assert property (bus_cs_n && bus_transfer_ack_n ##1 !bus_cs_n
        |=> !bus_transfer_ack_n) else $error("no answer to a taken cycle");
    a_ack_stands: assert property (!bus_transfer_ack_n && !bus_cs_n
        |=> !bus_transfer_ack_n) else $error("answer dropped while strobe held");
    a_ack_ends: assert property (!bus_transfer_ack_n && bus_cs_n && timer_int_ack_pin_n
        |=> bus_transfer_ack_n) else $error("answer held after release");
    a_oe_in_ack: assert property (bus_rdata_oe |-> !bus_transfer_ack_n)
        else $error("data driven outside an answer");
    a_rdata_quiet: assert property (!bus_rdata_oe |-> bus_rdata == 8'h00)
        else $error("read data not zero while idle");
    a_iack_needs_req: assert property ($fell(bus_transfer_ack_n) && bus_cs_n
        |-> $past(timer_int_ack_sel && timer_output_oe && !timer_output_pin))
        else $error("acknowledge answered without request");
    a_req_follows_flag: assert property (timer_int_ack_sel && timer_output_oe
        |-> zero_reached_flag && !timer_output_pin) else $error("request without flag");
    a_read_keeps_flag: assert property (!bus_cs_n && bus_rd_wr && zero_reached_flag
        && !ext_input_sel |=> zero_reached_flag) else $error("read cleared the flag");
endmodule
`default_nettype wire

// ### bench/pdt_host.sv
// host bus model: register cycles and timer interrupt acknowledge cycles
// assumes the timer answers within a few clocks and holds ack until release
`timescale 1ns/1ps
`default_nettype none
module pdt_host
(
    input  wire logic       clk,
    input  wire logic [7:0] bus_rdata,
    input  wire logic       bus_transfer_ack_n,
    output var logic        bus_cs_n,
    output var logic        bus_rd_wr,
    output var logic [4:0]  bus_addr,
    output var logic [7:0]  bus_wdata,
    output var logic        timer_int_ack_pin_n
);
    initial
    begin
        bus_cs_n = 1'b1;
        bus_rd_wr = 1'b1;
        bus_addr = 5'h00;
        bus_wdata = 8'h00;
        timer_int_ack_pin_n = 1'b1;
    end
    // ia picks an acknowledge cycle; got tells whether the timer answered
    task automatic cyc(input logic ia, input logic rw, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q, output logic got);
        int i;
        @(posedge clk);
        bus_cs_n <= ia;
        timer_int_ack_pin_n <= !ia;
        bus_rd_wr <= rw;
        bus_addr <= a;
        bus_wdata <= d;
        for (i = 0; i < 6 && bus_transfer_ack_n !== 1'b0; i++)
            @(posedge clk);
        got = (bus_transfer_ack_n === 1'b0);
        q = bus_rdata;
        bus_cs_n <= 1'b1;
        timer_int_ack_pin_n <= 1'b1;
        // released lines show a changed pattern, never the last value
        bus_addr <= ~a;
        bus_wdata <= ~d;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench of the timer section with a host bus model
// assumes the design files under hw/ and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       clk;
    logic       reset_n;
    logic       ext_timer_input;
    int         mismatches = 0;
    int         n_checks = 0;
    wire        bus_cs_n, bus_rd_wr, bus_rdata_oe, bus_transfer_ack_n, timer_int_ack_pin_n;
    wire        timer_output_pin, timer_output_oe, timer_int_ack_sel, ext_input_sel;
    wire        zero_reached_flag;
    wire  [4:0] bus_addr;
    wire  [7:0] bus_wdata, bus_rdata;
    pdt_host host (.clk(clk), .bus_rdata(bus_rdata), .bus_transfer_ack_n(bus_transfer_ack_n),
        .bus_cs_n(bus_cs_n), .bus_rd_wr(bus_rd_wr), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .timer_int_ack_pin_n(timer_int_ack_pin_n));
    pdt_timer dut (.clk(clk), .reset_n(reset_n), .bus_cs_n(bus_cs_n), .bus_rd_wr(bus_rd_wr),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_rdata_oe(bus_rdata_oe), .bus_transfer_ack_n(bus_transfer_ack_n),
        .timer_int_ack_pin_n(timer_int_ack_pin_n), .ext_timer_input(ext_timer_input),
        .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
        .timer_int_ack_sel(timer_int_ack_sel), .ext_input_sel(ext_input_sel),
        .zero_reached_flag(zero_reached_flag));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic ia, input logic rw, input logic [4:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        logic got;
        host.cyc(ia, rw, a, d, q, got);
        chk("answer", 1'b1, got);
        if (got !== 1'b1)
            summarize();
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b0, 1'b0, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input string what, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, 1'b1, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    // 8 high then 8 low keeps the step rate at a sixteenth of clk
    task automatic pulse();
        ext_timer_input <= 1'b1;
        repeat (8) @(posedge clk);
        ext_timer_input <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    // bounded wait for the zero flag; a timeout ends the run
    task automatic wait_zero(output int n);
        for (n = 0; n < 200 && zero_reached_flag !== 1'b1; n++)
            @(posedge clk);
        chk("zero wait", 1'b1, zero_reached_flag);
        if (zero_reached_flag !== 1'b1)
            summarize();
    endtask
    task automatic t_reset();
        rd(5'h11, "vector", 8'h0f);
        rd(5'h10, "config", 8'h00);
        chk("pin sel", 3'b000, {ext_input_sel, timer_int_ack_sel, timer_output_oe});
        wr(5'h11, 8'h5a);
        rd(5'h11, "vector rw", 8'h5a);
        wr(5'h13, 8'h00);
        wr(5'h14, 8'h00);
        wr(5'h15, 8'h02);
        wr(5'h12, 8'hff);
        wr(5'h16, 8'hff);
        wr(5'h17, 8'hff);
        rd(5'h12, "null reload", 8'h00);
        rd(5'h16, "null count", 8'h00);
        rd(5'h13, "reload high", 8'h00);
        rd(5'h15, "reload low", 8'h02);
    endtask
    task automatic t_periodic();
        logic [7:0] q;
        logic got;
        int n;
        wr(5'h10, 8'ha1);
        wait_zero(n);
        chk("zero time", 1'b1, n > 84 && n < 100);
        chk("request", 3'b110, {timer_int_ack_sel, timer_output_oe, timer_output_pin});
        rd(5'h1a, "flags", 8'h01);
        rd(5'h1a, "flags again", 8'h01);
        bus(1'b1, 1'b1, 5'h00, 8'h00, q);
        chk("iack vector", 8'h5a, q);
        wr(5'h1a, 8'h01);
        chk("flag clear", 1'b0, zero_reached_flag);
        host.cyc(1'b1, 1'b1, 5'h00, 8'h00, q, got);
        chk("iack silent", 1'b0, got);
        // halted before the step that would reload, so the counter rests at zero
        wr(5'h10, 8'ha0);
        rd(5'h19, "count low", 8'h00);
        rd(5'h19, "held count", 8'h00);
        rd(5'h17, "count high", 8'h00);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(5'h19, "count kept", 8'h00);
        rd(5'h15, "reload kept", 8'h02);
        rd(5'h11, "vector reset", 8'h0f);
    endtask
    task automatic t_ext();
        wr(5'h10, 8'h17);
        chk("ext sel", 1'b1, ext_input_sel);
        pulse();
        pulse();
        chk("no early zero", 1'b0, zero_reached_flag);
        pulse();
        chk("zero on step", 1'b1, zero_reached_flag);
        pulse();
        rd(5'h17, "roll high", 8'hff);
        rd(5'h19, "roll low", 8'hff);
        wr(5'h19, 8'h00);
        rd(5'h19, "count write dropped", 8'hff);
        wr(5'h10, 8'h00);
        chk("halt flag", 1'b0, zero_reached_flag);
    endtask
    task automatic t_square();
        logic [7:0] q;
        logic got;
        int n;
        wr(5'h10, 8'h40);
        chk("square idle", 2'b11, {timer_output_oe, timer_output_pin});
        wr(5'h10, 8'h41);
        wait_zero(n);
        chk("square toggled", 1'b0, timer_output_pin);
        host.cyc(1'b1, 1'b1, 5'h00, 8'h00, q, got);
        chk("iack square", 1'b0, got);
        wr(5'h10, 8'h40);
        chk("square halt", 2'b11, {timer_output_oe, timer_output_pin});
        chk("square halt flag", 1'b0, zero_reached_flag);
    endtask
    // a free-running timer would have loaded the reload value within 40 clocks
    task automatic t_gated();
        wr(5'h10, 8'h03);
        repeat (40) @(posedge clk);
        rd(5'h19, "gated low", 8'h00);
        ext_timer_input <= 1'b1;
        repeat (40) @(posedge clk);
        rd(5'h19, "gated run", 8'h02);
        ext_timer_input <= 1'b0;
        repeat (40) @(posedge clk);
        rd(5'h19, "gated halt", 8'h02);
    endtask
    // 32 input edges per prescaler rollover; only the 32nd loads the counter
    task automatic t_presc();
        wr(5'h15, 8'h05);
        wr(5'h10, 8'h05);
        repeat (31) pulse();
        rd(5'h19, "presc hold", 8'h02);
        pulse();
        rd(5'h19, "presc load", 8'h05);
        wr(5'h10, 8'h00);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        reset_n = 1'b0;
        ext_timer_input = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_periodic();
        t_ext();
        t_square();
        t_gated();
        t_presc();
        summarize();
    end
endmodule
bind pdt_timer pdt_timer_props chk_i (.clk(clk), .reset_n(reset_n), .bus_cs_n(bus_cs_n),
    .bus_rd_wr(bus_rd_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_rdata_oe(bus_rdata_oe), .bus_transfer_ack_n(bus_transfer_ack_n),
    .timer_int_ack_pin_n(timer_int_ack_pin_n), .ext_timer_input(ext_timer_input),
    .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe),
    .timer_int_ack_sel(timer_int_ack_sel), .ext_input_sel(ext_input_sel),
    .zero_reached_flag(zero_reached_flag));
`default_nettype wire
